/* File: ioct_regs.svh */
// register offsets, field positions, reset values and limits of the overcurrent trip block
`ifndef IOCT_REGS_SVH
`define IOCT_REGS_SVH

`define IOCT_CTRL_OFS       12'h000
`define IOCT_PICKUP_OFS     12'h004
`define IOCT_STATUS_OFS     12'h008
`define IOCT_IRQ_STAT_OFS   12'h00c
`define IOCT_IRQ_EN_OFS     12'h010
`define IOCT_IRQ_CLR_OFS    12'h014
`define IOCT_RATED_OFS      12'h018

`define IOCT_CTRL_MODE_LSB  0
`define IOCT_CTRL_MODE_MSB  1
`define IOCT_CTRL_RST       2'h0
`define IOCT_PICKUP_RST    12'hc8
`define IOCT_PICKUP_MIN    12'h014
`define IOCT_PICKUP_MAX    12'hbb8
`define IOCT_RATED_RST     16'h0100
`define IOCT_PCT_DIV       24'h000064

`endif

/* File: ioct_pkg.sv */
// types shared by the overcurrent trip block
package ioct_pkg;

  typedef enum logic [1:0]
  {
    IOCT_MODE_OFF  = 2'h0,
    IOCT_MODE_PEAK = 2'h1,
    IOCT_MODE_FUND = 2'h2
  } ioct_mode_t;

  typedef struct packed
  {
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] c;
  } ioct_phase3_t;

  typedef struct packed
  {
    logic general;
    logic c;
    logic b;
    logic a;
  } ioct_trip_t;

endpackage

/* File: ioct_peak.sv */
// per-phase magnitude of the latest valid sample of one signed sample stream
`timescale 1ns/1ps

module ioct_peak
(
  input  wire logic        mclk_i,
  input  wire logic        reset_n_i,
  input  wire logic        sample_valid_i,
  input  wire logic [15:0] sample_i,
  output logic      [15:0] peak_o
);

  logic [15:0] mag;
  logic [15:0] peak_r;

  // magnitude of the two's complement sample, most negative clamps
  assign mag = sample_i[15] ? ((sample_i == 16'h8000) ? 16'h7fff : 16'(-sample_i)) : sample_i;

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      peak_r <= 16'h0000;
    else if (sample_valid_i)
      peak_r <= mag;
  end

  assign peak_o = peak_r;

endmodule

/* File: ioct_top.sv */
// three-phase instantaneous overcurrent trip decision with axi4-lite registers
//
// Contract
// - the magnitude of the latest valid sample is registered for each phase separately and compared.
// - a phase trips with no added delay once its quantity exceeds threshold.
// - fundamental mode compares rms inputs; peak mode compares per-phase latest sample magnitudes.
// - mode is off, peak or fundamental; resets off; off never trips.
// - pickup is an integer percent, 20 to 3000, step 1, default 200.
// - block request disables the function and holds every trip low.
// - double request makes the threshold twice the pickup for all phases.
// - three phase trip outputs, each showing only its own phase result.
// - one general trip is formed from the three phase trips.
// - general trip is high while at least one phase trip is high.
`timescale 1ns/1ps
`include "ioct_regs.svh"

module ioct_top
(
  input  wire logic                  mclk_i,
  input  wire logic                  reset_n_i,
  input  wire logic                  sample_valid_i,
  input  wire ioct_pkg::ioct_phase3_t phase_current_i,
  input  wire ioct_pkg::ioct_phase3_t phase_fundamental_rms_i,
  input  wire logic                  block_request_i,
  input  wire logic                  threshold_double_request_i,
  output logic                       phase_a_trip_o,
  output logic                       phase_b_trip_o,
  output logic                       phase_c_trip_o,
  output logic                       general_trip_out_o,
  output logic                       irq_o,
  input  wire logic [11:0]           s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [11:0]           s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready
);

  import ioct_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // threshold in current units: rated * percent / 100
  function automatic logic [23:0] pct_to_level(input logic [15:0] rated, input logic [12:0] pct);
    logic [28:0] prod;
    prod = 29'(rated) * 29'(pct);
    return 24'(prod / 29'(`IOCT_PCT_DIV));
  endfunction

  // byte lanes of a write into a register word
  function automatic logic [31:0] strobe_merge(input logic [31:0] old, input logic [31:0] data,
                                               input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        res[i*8 +: 8] = data[i*8 +: 8];
    return res;
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------

  logic [1:0]  mode_r;
  logic [11:0] pickup_r;
  logic [15:0] rated_r;
  logic [3:0]  irq_stat_r;
  logic [3:0]  irq_en_r;
  ioct_trip_t  trip_r;
  ioct_trip_t  trip_nxt;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------

  logic [1:0] ctl_meta_r;
  logic [1:0] ctl_sync_r;
  logic       blk_s;
  logic       dbl_s;

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ctl_meta_r <= 2'h0;
      ctl_sync_r <= 2'h0;
    end
    else
    begin
      ctl_meta_r <= {threshold_double_request_i, block_request_i};
      ctl_sync_r <= ctl_meta_r;
    end
  end

  assign blk_s = ctl_sync_r[0];
  assign dbl_s = ctl_sync_r[1];

  // ----------------------------------------------------------------
  // peak selection
  // ----------------------------------------------------------------

  ioct_phase3_t peak;

  ioct_peak u_peak_a
  (
    .mclk_i         (mclk_i),
    .reset_n_i      (reset_n_i),
    .sample_valid_i (sample_valid_i),
    .sample_i       (phase_current_i.a),
    .peak_o         (peak.a)
  );

  ioct_peak u_peak_b
  (
    .mclk_i         (mclk_i),
    .reset_n_i      (reset_n_i),
    .sample_valid_i (sample_valid_i),
    .sample_i       (phase_current_i.b),
    .peak_o         (peak.b)
  );

  ioct_peak u_peak_c
  (
    .mclk_i         (mclk_i),
    .reset_n_i      (reset_n_i),
    .sample_valid_i (sample_valid_i),
    .sample_i       (phase_current_i.c),
    .peak_o         (peak.c)
  );

  // ----------------------------------------------------------------
  // instantaneous decision
  // ----------------------------------------------------------------

  ioct_phase3_t meas;
  wire  [12:0]  pct_act;
  wire  [23:0]  thresh;
  wire          enabled;

  assign meas    = (mode_r == IOCT_MODE_FUND) ? phase_fundamental_rms_i : peak;
  assign pct_act = dbl_s ? {pickup_r, 1'b0} : {1'b0, pickup_r};
  assign thresh  = pct_to_level(rated_r, pct_act);
  assign enabled = (mode_r != IOCT_MODE_OFF) && !blk_s;

  // combinational compare, one register stage, no timers
  assign trip_nxt.a       = enabled && (24'(meas.a) > thresh);
  assign trip_nxt.b       = enabled && (24'(meas.b) > thresh);
  assign trip_nxt.c       = enabled && (24'(meas.c) > thresh);
  assign trip_nxt.general = trip_nxt.a | trip_nxt.b | trip_nxt.c;

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      trip_r <= '0;
    else
      trip_r <= trip_nxt;
  end

  assign phase_a_trip_o     = trip_r.a;
  assign phase_b_trip_o     = trip_r.b;
  assign phase_c_trip_o     = trip_r.c;
  assign general_trip_out_o = trip_r.general;

  // ----------------------------------------------------------------
  // interrupts: rising edge of each trip sets a sticky bit
  // ----------------------------------------------------------------

  wire [3:0] trip_rise = trip_nxt & ~trip_r;

  assign irq_o = |(irq_stat_r & irq_en_r);

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------

  logic        aw_held_r;
  logic        w_held_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;

  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire  = s_axi_wvalid && s_axi_wready;
  wire wr_go   = aw_held_r && w_held_r && !bvalid_r;

  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready  = !w_held_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awaddr_r  <= 12'h000;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
    end
    else
    begin
      if (aw_fire)
      begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      else if (wr_go)
        aw_held_r <= 1'b0;
      if (w_fire)
      begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      else if (wr_go)
        w_held_r <= 1'b0;
    end
  end

  // write decode
  wire [11:0] wa       = {awaddr_r[11:2], 2'b00};
  wire        wr_ctrl  = wr_go && (wa == `IOCT_CTRL_OFS);
  wire        wr_pick  = wr_go && (wa == `IOCT_PICKUP_OFS);
  wire        wr_en    = wr_go && (wa == `IOCT_IRQ_EN_OFS);
  wire        wr_clr   = wr_go && (wa == `IOCT_IRQ_CLR_OFS);
  wire        wr_rated = wr_go && (wa == `IOCT_RATED_OFS);
  wire        wr_ok    = wr_ctrl || wr_pick || wr_en || wr_clr || wr_rated
                         || (wa == `IOCT_STATUS_OFS) || (wa == `IOCT_IRQ_STAT_OFS);
  wire [31:0] ctrl_new = strobe_merge({30'h0, mode_r}, wdata_r, wstrb_r);
  wire [31:0] pick_new = strobe_merge({20'h0, pickup_r}, wdata_r, wstrb_r);
  wire [31:0] rat_new  = strobe_merge({16'h0, rated_r}, wdata_r, wstrb_r);
  wire [1:0]  mode_w   = ctrl_new[`IOCT_CTRL_MODE_MSB:`IOCT_CTRL_MODE_LSB];
  wire        pick_ok  = (pick_new[31:12] == 20'h0) && (pick_new[11:0] >= `IOCT_PICKUP_MIN)
                         && (pick_new[11:0] <= `IOCT_PICKUP_MAX);
  wire [3:0]  clr_bits = (wr_clr && wstrb_r[0]) ? wdata_r[3:0] : 4'h0;

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      mode_r     <= `IOCT_CTRL_RST;
      pickup_r   <= `IOCT_PICKUP_RST;
      rated_r    <= `IOCT_RATED_RST;
      irq_en_r   <= 4'h0;
      irq_stat_r <= 4'h0;
      bvalid_r   <= 1'b0;
      bresp_r    <= 2'h0;
    end
    else
    begin
      if (wr_ctrl && (mode_w != 2'h3))
        mode_r <= mode_w;
      if (wr_pick && pick_ok)
        pickup_r <= pick_new[11:0];
      if (wr_rated)
        rated_r <= rat_new[15:0];
      if (wr_en && wstrb_r[0])
        irq_en_r <= wdata_r[3:0];
      irq_stat_r <= (irq_stat_r & ~clr_bits) | trip_rise;   // set wins over clear
      if (wr_go)
      begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_ok ? 2'h0 : 2'h2;
      end
      else if (s_axi_bready)
        bvalid_r <= 1'b0;
    end
  end

  // read decode
  wire [11:0] ra     = {s_axi_araddr[11:2], 2'b00};
  wire        rd_hit = (ra == `IOCT_CTRL_OFS) || (ra == `IOCT_PICKUP_OFS)
                       || (ra == `IOCT_STATUS_OFS) || (ra == `IOCT_IRQ_STAT_OFS)
                       || (ra == `IOCT_IRQ_EN_OFS) || (ra == `IOCT_IRQ_CLR_OFS)
                       || (ra == `IOCT_RATED_OFS);
  wire [31:0] rd_val = (ra == `IOCT_CTRL_OFS)     ? {30'h0, mode_r}
                     : (ra == `IOCT_PICKUP_OFS)   ? {20'h0, pickup_r}
                     : (ra == `IOCT_STATUS_OFS)   ? {26'h0, dbl_s, blk_s, trip_r}
                     : (ra == `IOCT_IRQ_STAT_OFS) ? {28'h0, irq_stat_r}
                     : (ra == `IOCT_IRQ_EN_OFS)   ? {28'h0, irq_en_r}
                     : (ra == `IOCT_RATED_OFS)    ? {16'h0, rated_r}
                     : 32'h0000_0000;

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= 2'h0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_val;
      rresp_r  <= rd_hit ? 2'h0 : 2'h2;
    end
    else if (s_axi_rready)
      rvalid_r <= 1'b0;
  end

endmodule

/* File: ioct_top_checker.sv */
// assertions on the ports of the overcurrent trip block
`timescale 1ns/1ps

module ioct_top_checker
(
  input wire logic                   mclk_i,
  input wire logic                   reset_n_i,
  input wire logic                   sample_valid_i,
  input wire ioct_pkg::ioct_phase3_t phase_current_i,
  input wire ioct_pkg::ioct_phase3_t phase_fundamental_rms_i,
  input wire logic                   block_request_i,
  input wire logic                   phase_a_trip_o,
  input wire logic                   phase_b_trip_o,
  input wire logic                   phase_c_trip_o,
  input wire logic                   general_trip_out_o,
  input wire logic                   s_axi_awvalid,
  input wire logic                   s_axi_awready,
  input wire logic                   s_axi_wvalid,
  input wire logic                   s_axi_wready,
  input wire logic                   s_axi_bvalid,
  input wire logic                   s_axi_arvalid,
  input wire logic                   s_axi_arready,
  input wire logic                   s_axi_rvalid,
  input wire logic                   s_axi_rready
);
  import ioct_pkg::*;
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_block_held;
    block_request_i [*4];
  endsequence
  sequence s_b_quiet;
    (phase_fundamental_rms_i.b == 16'h0000 && phase_current_i.b == 16'h0000
     && sample_valid_i) [*3];
  endsequence
  wire logic any_trip = phase_a_trip_o | phase_b_trip_o | phase_c_trip_o;
  a_general_or:
    assert property (general_trip_out_o == any_trip) else $error("general trip mismatch");
  a_block_clears:
    assert property (s_block_held |=> !any_trip && !general_trip_out_o)
      else $error("trip while blocked");
  a_b_own_phase:
    assert property (s_b_quiet |=> !phase_b_trip_o) else $error("phase b trip with no current");
  a_write_answer:
    assert property (s_write_taken |=> ##1 s_axi_bvalid) else $error("write response late");
  a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
  a_read_release:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid held");
  a_ar_refused:
    assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready during rvalid");
  a_aw_refused:
    assert property (s_axi_bvalid |-> !s_axi_awready) else $error("awready during bvalid");
endmodule

bind ioct_top ioct_top_checker i_ioct_top_checker (.mclk_i, .reset_n_i, .sample_valid_i,
  .phase_current_i, .phase_fundamental_rms_i, .block_request_i, .phase_a_trip_o,
  .phase_b_trip_o, .phase_c_trip_o, .general_trip_out_o, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready);

/* File: ioct_logic_model.sv */
// user logic equations and upstream rms stage feeding the trip block
`timescale 1ns/1ps

module ioct_logic_model
(
  input  wire logic                   mclk_i,
  input  wire logic                   reset_n_i,
  input  wire logic                   blk_cmd_i,
  input  wire logic                   dbl_cmd_i,
  input  wire ioct_pkg::ioct_phase3_t rms_cmd_i,
  output logic                        block_request_o,
  output logic                        threshold_double_request_o,
  output ioct_pkg::ioct_phase3_t      rms_o
);
  import ioct_pkg::*;
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      block_request_o            <= 1'b0;
      threshold_double_request_o <= 1'b0;
      rms_o                      <= '0;
    end
    else
    begin
      block_request_o            <= blk_cmd_i;
      threshold_double_request_o <= dbl_cmd_i;
      rms_o                      <= rms_cmd_i;
    end
  end
endmodule

/* File: three_phase_instant_overcurrent_trip_bench.sv */
// self-checking bench of the overcurrent trip block
`timescale 1ns/1ps
`include "ioct_regs.svh"

module three_phase_instant_overcurrent_trip_bench;
  import ioct_pkg::*;
  logic mclk_i, reset_n_i, sample_valid_i, blk_cmd, dbl_cmd, block_request_i;
  logic threshold_double_request_i, phase_a_trip_o, phase_b_trip_o, phase_c_trip_o;
  logic general_trip_out_o, irq_o, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  ioct_phase3_t phase_current_i, phase_fundamental_rms_i, rms_cmd;
  int failures, comparisons;

  ioct_top i_ioct_top (.mclk_i, .reset_n_i, .sample_valid_i, .phase_current_i,
    .phase_fundamental_rms_i, .block_request_i, .threshold_double_request_i, .phase_a_trip_o,
    .phase_b_trip_o, .phase_c_trip_o, .general_trip_out_o, .irq_o, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  ioct_logic_model i_ioct_logic_model (.mclk_i, .reset_n_i, .blk_cmd_i(blk_cmd),
    .dbl_cmd_i(dbl_cmd), .rms_cmd_i(rms_cmd), .block_request_o(block_request_i),
    .threshold_double_request_o(threshold_double_request_i), .rms_o(phase_fundamental_rms_i));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e)
    begin
      failures++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge mclk_i);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(s_axi_bresp), 32'h0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge mclk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge mclk_i);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    chk("rresp", 32'(s_axi_rresp), 32'(er));
    if (er == 2'h0) chk("rdata", s_axi_rdata, e);
  endtask
  // drive rms a and c, current b, block, double; then compare trips
  task automatic st(input logic [15:0] ra, rc, cb, input logic bk, db, input logic [3:0] e);
    @(posedge mclk_i);
    rms_cmd.a <= ra;
    rms_cmd.c <= rc;
    phase_current_i.b <= cb;
    blk_cmd <= bk;
    dbl_cmd <= db;
    repeat (6) @(posedge mclk_i);
    #1;
    chk("trips", 32'(e), 32'({general_trip_out_o, phase_c_trip_o, phase_b_trip_o,
      phase_a_trip_o}));
  endtask
  task automatic close_out;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  initial
  begin
    #100000;
    failures++;
    close_out;
  end
  initial
  begin
    {reset_n_i, blk_cmd, dbl_cmd, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {failures, comparisons, phase_current_i, rms_cmd} = '0;
    s_axi_wstrb = 4'hf;
    sample_valid_i = 1'b1;
    repeat (3) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    rd(`IOCT_CTRL_OFS, 32'h0, 2'h0);
    rd(`IOCT_PICKUP_OFS, 32'h0000_00c8, 2'h0);
    rd(`IOCT_RATED_OFS, 32'h0000_0100, 2'h0);
    st(16'h0201, 16'h0000, 16'h0000, 1'b0, 1'b0, 4'h0);
    wr(`IOCT_IRQ_EN_OFS, 32'h1);
    wr(`IOCT_CTRL_OFS, 32'h2);
    st(16'h0201, 16'h0000, 16'h0000, 1'b0, 1'b0, 4'h9);
    chk("irq", 32'(irq_o), 32'h1);
    st(16'h0200, 16'h0000, 16'h0000, 1'b0, 1'b0, 4'h0);
    wr(`IOCT_IRQ_CLR_OFS, 32'h1);
    #1;
    chk("irq", 32'(irq_o), 32'h0);
    st(16'h03e8, 16'h0000, 16'h0000, 1'b0, 1'b1, 4'h0);
    st(16'h03e8, 16'h0000, 16'h0000, 1'b0, 1'b0, 4'h9);
    st(16'h03e8, 16'h0000, 16'h0000, 1'b1, 1'b0, 4'h0);
    st(16'h03e8, 16'h0000, 16'hfda8, 1'b0, 1'b0, 4'h9);
    wr(`IOCT_CTRL_OFS, 32'h1);
    st(16'h03e8, 16'h0000, 16'hfda8, 1'b0, 1'b0, 4'ha);
    st(16'h03e8, 16'h0000, 16'h0000, 1'b0, 1'b0, 4'h0);
    wr(`IOCT_CTRL_OFS, 32'h3);
    rd(`IOCT_CTRL_OFS, 32'h1, 2'h0);
    wr(`IOCT_PICKUP_OFS, 32'h0000_0013);
    rd(`IOCT_PICKUP_OFS, 32'h0000_00c8, 2'h0);
    wr(`IOCT_PICKUP_OFS, 32'h0000_0bb9);
    rd(`IOCT_PICKUP_OFS, 32'h0000_00c8, 2'h0);
    wr(`IOCT_PICKUP_OFS, 32'h0000_0bb8);
    rd(`IOCT_PICKUP_OFS, 32'h0000_0bb8, 2'h0);
    wr(`IOCT_PICKUP_OFS, 32'h0000_0014);
    wr(`IOCT_CTRL_OFS, 32'h2);
    st(16'h0000, 16'h0034, 16'h0000, 1'b0, 1'b0, 4'hc);
    rd(`IOCT_STATUS_OFS, 32'h0000_000c, 2'h0);
    rd(`IOCT_IRQ_STAT_OFS, 32'h0000_000f, 2'h0);
    rd(`IOCT_IRQ_EN_OFS, 32'h0000_0001, 2'h0);
    rd(`IOCT_IRQ_CLR_OFS, 32'h0000_0000, 2'h0);
    chk("irq", 32'(irq_o), 32'h1);
    st(16'h0000, 16'h0033, 16'h0000, 1'b0, 1'b0, 4'h0);
    wr(`IOCT_RATED_OFS, 32'h0000_0200);
    rd(`IOCT_RATED_OFS, 32'h0000_0200, 2'h0);
    st(16'h0000, 16'h0067, 16'h0000, 1'b0, 1'b0, 4'hc);
    st(16'h0000, 16'h0066, 16'h0000, 1'b0, 1'b0, 4'h0);
    rd(12'h01c, 32'h0, 2'h2);
    close_out;
  end
endmodule
